// ==== include/resample_pkg.sv ====
package resample_pkg;
	localparam int SAMPLE_W = 16;
	localparam int CTRL_W = 16;
	localparam int FACTOR_W = 4;
	localparam int UP_W = 20;
	localparam int ACC_W = 40;
	localparam int TAPS = 7;
	localparam int COEF_Q = 15;
	localparam int IIR_SHIFT = 3;
	localparam logic [FACTOR_W-1:0] FACTOR_ONE = 4'h1;
	localparam logic [FACTOR_W-1:0] FACTOR_RESET = 4'h5;
	localparam logic [FACTOR_W-1:0] PHASE_FIRST = 4'h0;
	localparam logic signed [ACC_W-1:0] SAT_HI = 40'sh0000007FFF;
	localparam logic signed [ACC_W-1:0] SAT_LO = 40'shFFFFFF8000;
	localparam logic signed [SAMPLE_W-1:0] SAMPLE_ZERO = 16'sh0000;
	// plain symmetric low-pass, Q15; replace with a designed set per rate
	localparam logic signed [SAMPLE_W-1:0] COEF [TAPS] = '{16'sh0400, 16'sh0C00, 16'sh1800, 16'sh1C00,
		16'sh1800, 16'sh0C00, 16'sh0400};

	// one 32-bit codec transfer: audio in the upper half
	typedef struct packed {
		logic signed [SAMPLE_W-1:0] audio;
		logic [CTRL_W-1:0] ctrl;
	} codec_word_t;

	typedef enum logic [3:0] {DEC_FIR = 4'h1, DEC_IIR = 4'h2, DEC_AVG = 4'h4, DEC_DROP = 4'h8} dec_mode_t;
	typedef enum logic [2:0] {INT_FIR = 3'h1, INT_ZERO = 3'h2, INT_HOLD = 3'h4} int_mode_t;

	// factors whose processing rate divides 40 kHz exactly
	function automatic logic factor_legal(input logic [FACTOR_W-1:0] d);
		return d == 4'h1 || d == 4'h2 || d == 4'h4 || d == 4'h5 || d == 4'h8 || d == 4'hA;
	endfunction

	// 1/d in Q15 for the averaging mode
	function automatic logic [SAMPLE_W-1:0] recip(input logic [FACTOR_W-1:0] d);
		logic [SAMPLE_W-1:0] r;
		r = 16'h7FFF;
		case (d)
			4'h2: r = 16'h4000;
			4'h4: r = 16'h2000;
			4'h5: r = 16'h199A;
			4'h8: r = 16'h1000;
			4'hA: r = 16'h0CCD;
			default: r = 16'h7FFF;
		endcase
		return r;
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [ACC_W-1:0] v);
		logic signed [SAMPLE_W-1:0] r;
		r = SAMPLE_W'(v);
		if (v > SAT_HI) r = SAMPLE_W'(SAT_HI);
		if (v < SAT_LO) r = SAMPLE_W'(SAT_LO);
		return r;
	endfunction
endpackage

// ==== hdl/resampler.sv ====
`timescale 1ns/1ns
// multiply-accumulate over a tap window; shared by both filters
module fir_mac
	import resample_pkg::*;
#(
	parameter int IN_W = 16 // width of one tap
) (
	input wire logic signed [IN_W-1:0] taps [TAPS], // tap window, newest first
	output logic signed [ACC_W-1:0] sum // full-precision sum
);
	always_comb begin
		sum = '0;
		for (int i = 0; i < TAPS; i++) begin
			// widen both operands first so the product keeps its full precision
			sum = sum + ACC_W'(taps[i]) * ACC_W'(COEF[i]);
		end
	end
endmodule

// Contract
// - FIR decimator evaluates once per group
// - every sample enters the delay line
// - recursive decimator updates on every sample
// - interpolation runs at full codec slot rate
// - unfiltered: sample once, then zeros or repeats
// - one consumer pulse per D samples
// - optional averaging or dropping decimation
// - factor must divide 40 kHz exactly
// - 32-bit words, 16-bit audio extracted
module resampler
	import resample_pkg::*;
(
	input wire logic CLOCK, // 250 MHz system clock
	input wire logic RST, // async reset, active high
	input wire logic [FACTOR_W-1:0] FACTOR, // decimation factor D
	input wire dec_mode_t DEC_MODE, // decimation method
	input wire int_mode_t INT_MODE, // interpolation method
	input wire logic RX_VALID, // codec word strobe, one cycle
	input wire codec_word_t RX_WORD, // codec word in
	output logic DEC_VALID, // group complete pulse
	output logic signed [SAMPLE_W-1:0] DEC_SAMPLE, // decimated sample
	output logic FACTOR_ERR, // requested factor refused
	input wire logic PROC_VALID, // processed sample strobe
	input wire logic signed [SAMPLE_W-1:0] PROC_SAMPLE, // processed sample
	input wire logic [CTRL_W-1:0] TX_CTRL, // control half for output
	output logic TX_VALID, // output slot strobe
	output codec_word_t TX_WORD // codec word out
);
	logic [FACTOR_W-1:0] factor;
	logic [FACTOR_W-1:0] phase;
	logic signed [SAMPLE_W-1:0] dline [TAPS-1];
	logic signed [UP_W-1:0] uline [TAPS-1];
	logic signed [SAMPLE_W-1:0] iir_y;
	logic signed [ACC_W-1:0] acc;
	logic signed [SAMPLE_W-1:0] proc;
	logic fresh;
	logic signed [SAMPLE_W-1:0] dec_win [TAPS];
	logic signed [UP_W-1:0] up_win [TAPS];
	logic signed [ACC_W-1:0] fir_sum;
	logic signed [ACC_W-1:0] int_sum;
	logic signed [SAMPLE_W-1:0] dec_sel;
	logic signed [SAMPLE_W-1:0] tx_sel;

	// phase and factor decode
	wire logic signed [SAMPLE_W-1:0] x = RX_WORD.audio;
	wire logic factor_ok = factor_legal(FACTOR);
	wire logic last = phase == factor - FACTOR_ONE;
	wire logic group_end = RX_VALID && last;
	wire logic fir_en = group_end && DEC_MODE == DEC_FIR;

	// a new factor is only taken at a group boundary, so no group is cut short
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			phase <= PHASE_FIRST;
			factor <= FACTOR_RESET;
			FACTOR_ERR <= 1'b0;
		end else begin
			FACTOR_ERR <= !factor_ok;
			if (RX_VALID) begin
				phase <= last ? PHASE_FIRST : phase + FACTOR_ONE;
				if (last && factor_ok) factor <= FACTOR;
			end
		end
	end

	// decimation window; operands held at zero off-phase so the multipliers stay quiet
	assign dec_win[0] = fir_en ? x : SAMPLE_ZERO;
	generate
		for (genvar i = 1; i < TAPS; i++) begin : g_dwin
			assign dec_win[i] = fir_en ? dline[i-1] : SAMPLE_ZERO;
		end
	endgenerate

	fir_mac #(.IN_W(SAMPLE_W)) u_dec_fir (
		.taps(dec_win),
		.sum(fir_sum)
	);

	// recursive path and averaging arithmetic
	wire logic signed [SAMPLE_W:0] iir_diff = (SAMPLE_W+1)'(x) - (SAMPLE_W+1)'(iir_y);
	wire logic signed [SAMPLE_W-1:0] next_iir = iir_y + SAMPLE_W'(iir_diff >>> IIR_SHIFT);
	wire logic signed [ACC_W-1:0] acc_sum = (phase == PHASE_FIRST ? '0 : acc) + ACC_W'(x);
	wire logic signed [ACC_W-1:0] recip_ext = ACC_W'(recip(factor));
	wire logic signed [ACC_W-1:0] avg_prod = acc_sum * recip_ext;

	// every sample shifts in, skipped positions too, so nothing aliases
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			dline <= '{default: '0};
			iir_y <= SAMPLE_ZERO;
			acc <= '0;
		end else if (RX_VALID) begin
			dline[0] <= x;
			for (int i = 1; i < TAPS-1; i++) dline[i] <= dline[i-1];
			iir_y <= next_iir;
			acc <= acc_sum;
		end
	end

	// decimator result per method
	always_comb begin
		unique case (DEC_MODE)
			DEC_FIR: dec_sel = sat(fir_sum >>> COEF_Q);
			DEC_IIR: dec_sel = next_iir;
			DEC_AVG: dec_sel = sat(avg_prod >>> COEF_Q);
			DEC_DROP: dec_sel = x;
			default: dec_sel = x;
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			DEC_VALID <= 1'b0;
			DEC_SAMPLE <= SAMPLE_ZERO;
		end else begin
			DEC_VALID <= group_end;
			if (group_end) DEC_SAMPLE <= dec_sel;
		end
	end

	// processed sample waits for the next slot; a new arrival beats the consume
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			proc <= SAMPLE_ZERO;
			fresh <= 1'b0;
		end else if (PROC_VALID) begin
			proc <= PROC_SAMPLE;
			fresh <= 1'b1;
		end else if (RX_VALID) begin
			fresh <= 1'b0;
		end
	end

	// zero-stuffed input scaled by D keeps passband gain at unity
	wire logic signed [UP_W-1:0] up_x = fresh ? UP_W'(proc) * UP_W'($signed({1'b0, factor})) : '0;
	assign up_win[0] = up_x;
	generate
		for (genvar i = 1; i < TAPS; i++) begin : g_uwin
			assign up_win[i] = uline[i-1];
		end
	endgenerate

	fir_mac #(.IN_W(UP_W)) u_int_fir (
		.taps(up_win),
		.sum(int_sum)
	);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			uline <= '{default: '0};
		end else if (RX_VALID) begin
			uline[0] <= up_x;
			for (int i = 1; i < TAPS-1; i++) uline[i] <= uline[i-1];
		end
	end

	// output slot value; hold repeats the last word actually sent
	always_comb begin
		unique case (INT_MODE)
			INT_FIR: tx_sel = sat(int_sum >>> COEF_Q);
			INT_ZERO: tx_sel = fresh ? proc : SAMPLE_ZERO;
			INT_HOLD: tx_sel = fresh ? proc : TX_WORD.audio;
			default: tx_sel = SAMPLE_ZERO;
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			TX_VALID <= 1'b0;
			TX_WORD <= '0;
		end else begin
			TX_VALID <= RX_VALID;
			if (RX_VALID) TX_WORD <= '{audio: tx_sel, ctrl: TX_CTRL};
		end
	end

	phase_wrap_a: assert property (@(posedge CLOCK) disable iff (RST)
		RX_VALID && last |=> phase == PHASE_FIRST)
		else $error("phase did not wrap at group end");
	pulse_cause_a: assert property (@(posedge CLOCK) disable iff (RST)
		DEC_VALID |-> $past(RX_VALID) && $past(phase) == $past(factor) - FACTOR_ONE)
		else $error("group pulse without group end");
	single_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
		DEC_VALID |=> !DEC_VALID)
		else $error("group pulse longer than one cycle");
	shift_every_a: assert property (@(posedge CLOCK) disable iff (RST)
		RX_VALID |=> dline[0] == $past(x) && dline[1] == $past(dline[0]))
		else $error("sample not shifted into delay line");
	iir_output_a: assert property (@(posedge CLOCK) disable iff (RST)
		DEC_VALID && $past(DEC_MODE) == DEC_IIR |-> DEC_SAMPLE == iir_y)
		else $error("recursive output differs from state");
	slot_rate_a: assert property (@(posedge CLOCK) disable iff (RST)
		TX_VALID == $past(RX_VALID))
		else $error("output slot not paired with input slot");
	zero_fill_a: assert property (@(posedge CLOCK) disable iff (RST)
		TX_VALID && $past(INT_MODE) == INT_ZERO && !$past(fresh) |-> TX_WORD.audio == SAMPLE_ZERO)
		else $error("zero fill slot not zero");
	hold_fill_a: assert property (@(posedge CLOCK) disable iff (RST)
		TX_VALID && $past(INT_MODE) == INT_HOLD && !$past(fresh) |-> $stable(TX_WORD.audio))
		else $error("hold slot changed value");
	avg_restart_a: assert property (@(posedge CLOCK) disable iff (RST)
		RX_VALID && phase == PHASE_FIRST |=> acc == ACC_W'($past(x)))
		else $error("accumulator not restarted");
	factor_legal_a: assert property (@(posedge CLOCK) disable iff (RST)
		factor_legal(factor))
		else $error("illegal factor in use");
	reset_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
		$past(RST) |-> phase == PHASE_FIRST && acc == '0 && dline[0] == SAMPLE_ZERO)
		else $error("state not cleared by reset");
endmodule

// ==== bench/codec_model.sv ====
`timescale 1ns/1ns
// codec word source and processor sample source on the far side
module codec_model
	import resample_pkg::*;
(
	input wire logic clock, // system clock
	output logic rx_valid, // word strobe
	output codec_word_t rx_word, // word to block
	output logic proc_valid, // processed strobe
	output logic signed [SAMPLE_W-1:0] proc_sample, // processed sample
	output logic [CTRL_W-1:0] tx_ctrl // control half
);
	localparam int GAP = 6; // word spacing shortened from the real rate
	initial begin
		rx_valid = 1'b0;
		rx_word = '0;
		proc_valid = 1'b0;
		proc_sample = '0;
		tx_ctrl = 16'h00A5;
	end
	// one word per call, steady spacing; released word is inverted, not held
	task automatic send_word(input logic signed [SAMPLE_W-1:0] a);
		@(posedge clock);
		#1;
		rx_word = {a, 16'h0C0C};
		tx_ctrl = ~a;
		rx_valid = 1'b1;
		@(posedge clock);
		#1;
		rx_valid = 1'b0;
		rx_word = ~rx_word;
		repeat (GAP) @(posedge clock);
	endtask
	task automatic send_proc(input logic signed [SAMPLE_W-1:0] s);
		@(posedge clock);
		#1;
		proc_sample = s;
		proc_valid = 1'b1;
		@(posedge clock);
		#1;
		proc_valid = 1'b0;
		proc_sample = ~s;
	endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench
	import resample_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [FACTOR_W-1:0] factor = 4'h2;
	dec_mode_t dec_mode = DEC_DROP;
	int_mode_t int_mode = INT_ZERO;
	logic rx_valid, proc_valid, dec_valid, factor_err, tx_valid;
	codec_word_t rx_word, tx_word;
	logic signed [SAMPLE_W-1:0] proc_sample, dec_sample;
	logic [CTRL_W-1:0] tx_ctrl;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	int dec_cnt;
	logic [15:0] dec_last;
	logic [15:0] tx_q [$];
	always #2 clock = ~clock;
	resampler uut (.CLOCK(clock), .RST(rst), .FACTOR(factor), .DEC_MODE(dec_mode), .INT_MODE(int_mode),
		.RX_VALID(rx_valid), .RX_WORD(rx_word), .DEC_VALID(dec_valid), .DEC_SAMPLE(dec_sample),
		.FACTOR_ERR(factor_err), .PROC_VALID(proc_valid), .PROC_SAMPLE(proc_sample), .TX_CTRL(tx_ctrl),
		.TX_VALID(tx_valid), .TX_WORD(tx_word));
	codec_model far (.clock(clock), .rx_valid(rx_valid), .rx_word(rx_word), .proc_valid(proc_valid),
		.proc_sample(proc_sample), .tx_ctrl(tx_ctrl));
	// collect one-cycle pulses in the cycle they stand
	always @(posedge clock) begin
		if (dec_valid === 1'b1) begin
			dec_cnt++;
			dec_last = dec_sample;
		end
		if (tx_valid === 1'b1) tx_q.push_back(tx_word.audio);
	end
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic [3:0] f, input dec_mode_t dm, input int_mode_t im);
		@(posedge clock);
		#1;
		rst = 1'b1;
		factor = f;
		dec_mode = dm;
		int_mode = im;
		repeat (8) @(posedge clock);
		#1;
		rst = 1'b0;
		dec_cnt = 0;
		// the first group runs at the reset factor; the requested one is taken at its end
		repeat (FACTOR_RESET) far.send_word(SAMPLE_ZERO);
		cmp(16'(dec_cnt), 16'h0001);
		dec_cnt = 0;
		tx_q.delete();
	endtask
	task automatic t_drop();
		do_reset(4'h2, DEC_DROP, INT_ZERO);
		far.send_word(16'h1111);
		far.send_word(16'h2222);
		far.send_word(16'h3333);
		far.send_word(16'h4444);
		cmp(16'(dec_cnt), 16'h0002);
		cmp(dec_last, 16'h4444);
		cmp(tx_word.ctrl, 16'hBBBB);
	endtask
	task automatic t_avg();
		do_reset(4'h2, DEC_AVG, INT_ZERO);
		far.send_word(16'h0100);
		far.send_word(16'h0300);
		cmp(dec_last, 16'h0200);
	endtask
	// impulse in the skipped phase must still reach the output
	task automatic t_fir();
		do_reset(4'h2, DEC_FIR, INT_ZERO);
		far.send_word(16'h4000);
		far.send_word(16'h0000);
		cmp(16'(dec_cnt), 16'h0001);
		cmp(dec_last, 16'h0600);
	endtask
	task automatic t_iir();
		do_reset(4'h2, DEC_IIR, INT_ZERO);
		far.send_word(16'h0800);
		far.send_word(16'h0800);
		cmp(dec_last, 16'h01E0);
	endtask
	// filtered mode: sample scaled by D meets the first two taps in turn
	task automatic t_interp(input int_mode_t im, input logic [15:0] first, input logic [15:0] fill);
		do_reset(4'h2, DEC_DROP, im);
		far.send_proc(16'h1000);
		far.send_word(16'h0000);
		far.send_word(16'h0000);
		cmp(16'(tx_q.size()), 16'h0002);
		cmp(tx_q[0], first);
		cmp(tx_q[1], fill);
	endtask
	// an illegal factor is flagged and the running one is kept
	task automatic t_factor();
		do_reset(4'h2, DEC_DROP, INT_ZERO);
		@(posedge clock);
		#1;
		factor = 4'h3;
		far.send_word(16'h0001);
		far.send_word(16'h0002);
		cmp(16'(factor_err), 16'h0001);
		cmp(16'(dec_cnt), 16'h0001);
		@(posedge clock);
		#1;
		factor = 4'hA;
		repeat (3) @(posedge clock);
		#1;
		cmp(16'(factor_err), 16'h0000);
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		t_drop();
		t_avg();
		t_fir();
		t_iir();
		t_interp(INT_HOLD, 16'h1000, 16'h1000);
		t_interp(INT_ZERO, 16'h1000, 16'h0000);
		t_interp(INT_FIR, 16'h0100, 16'h0300);
		t_factor();
		report_and_stop();
	end
endmodule
